// [logic/baro_device.sv]
// Sensor end: two-wire target, command decoder, calibration store, conversions
`timescale 1ns/100ps
`include "baro_regs.svh"
module baro_device import baro_pkg::*; (
  input  wire logic   sys_clk,
  input  wire logic   rst,
  baro_bus_if.dev     bus,
  input  wire logic [23:0] pressure_sample,
  input  wire logic [23:0] temperature_sample,
  output logic        conversion_select_bit_busy,
  output logic        cal_loaded,
  output logic        meas_temp,
  output logic [2:0]  osr_sel
);
  // ----------------------------------------------------------------
  // Pin conditioning and bus events
  // ----------------------------------------------------------------
  logic scl_f;
  logic sda_f;
  logic scl_prev_reg;
  logic sda_prev_reg;

  baro_pin_sync u_scl_sync (
    .sys_clk (sys_clk),
    .rst     (rst),
    .pin     (bus.scl),
    .level   (scl_f)
  );
  baro_pin_sync u_sda_sync (
    .sys_clk (sys_clk),
    .rst     (rst),
    .pin     (bus.sda),
    .level   (sda_f)
  );

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      scl_prev_reg <= scl_f;
      sda_prev_reg <= sda_f;
    end
  end

  logic start_cond;
  logic stop_cond;
  logic scl_rise;
  logic scl_fall;
  assign start_cond = scl_f & scl_prev_reg & sda_prev_reg & ~sda_f;
  assign stop_cond  = scl_f & scl_prev_reg & ~sda_prev_reg & sda_f;
  assign scl_rise   = scl_f & ~scl_prev_reg;
  assign scl_fall   = ~scl_f & scl_prev_reg;

  // ----------------------------------------------------------------
  // Byte engine
  // ----------------------------------------------------------------
  baro_dev_state_type state_reg;
  logic [3:0]  bit_cnt_reg;
  logic [7:0]  rx_reg;
  logic [23:0] tx_reg;
  logic        rd_dir_reg;
  logic        sda_oe_reg;
  logic        cmd_exec;
  logic        rd_load;
  logic [23:0] rd_word;

  assign bus.dev_sda_out = 1'b0;
  assign bus.dev_sda_oe  = sda_oe_reg;

  assign cmd_exec = (state_reg == DEV_CMD) && scl_fall && (bit_cnt_reg == 4'h8);
  assign rd_load  = (state_reg == DEV_ADDR) && scl_fall && (bit_cnt_reg == 4'h9) && rd_dir_reg;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_reg   <= DEV_IDLE;
      bit_cnt_reg <= 4'h0;
      rx_reg      <= 8'h00;
      tx_reg      <= 24'hFFFFFF;
      rd_dir_reg  <= 1'b0;
      sda_oe_reg  <= 1'b0;
    end else if (start_cond) begin
      state_reg   <= DEV_ADDR; // R1
      bit_cnt_reg <= 4'h0;
      sda_oe_reg  <= 1'b0;
    end else if (stop_cond) begin
      state_reg   <= DEV_IDLE; // R1
      sda_oe_reg  <= 1'b0;
    end else begin
      unique case (state_reg)
        DEV_IDLE, DEV_IGNORE: begin
          sda_oe_reg <= 1'b0;
        end
        DEV_ADDR, DEV_CMD: begin
          if (scl_rise && bit_cnt_reg < 4'h8) begin
            rx_reg      <= {rx_reg[6:0], sda_f};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (scl_fall && bit_cnt_reg == 4'h8) begin
            if (state_reg == DEV_CMD) begin
              sda_oe_reg  <= 1'b1; // R18
              bit_cnt_reg <= 4'h9;
            end else if (rx_reg[7:1] == `BARO_ADDR) begin // R2
              sda_oe_reg  <= 1'b1; // R17 R18
              rd_dir_reg  <= rx_reg[0];
              bit_cnt_reg <= 4'h9;
            end else begin
              state_reg   <= DEV_IGNORE;
            end
          end else if (scl_fall && bit_cnt_reg == 4'h9) begin
            bit_cnt_reg <= 4'h0;
            if (state_reg == DEV_CMD) begin
              // Only one command per message; later bytes go unacknowledged
              sda_oe_reg <= 1'b0; // R1 R3
              state_reg  <= DEV_IGNORE;
            end else if (rd_dir_reg) begin
              tx_reg     <= rd_word; // R15
              sda_oe_reg <= ~rd_word[23];
              state_reg  <= DEV_SEND;
            end else begin
              sda_oe_reg <= 1'b0;
              state_reg  <= DEV_CMD; // R3
            end
          end
        end
        DEV_SEND: begin
          if (scl_fall) begin
            tx_reg <= {tx_reg[22:0], 1'b1};
            if (bit_cnt_reg == 4'h7) begin
              sda_oe_reg  <= 1'b0;
              bit_cnt_reg <= 4'h8;
              state_reg   <= DEV_HOSTACK;
            end else begin
              sda_oe_reg  <= ~tx_reg[22]; // R15
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
          end
        end
        DEV_HOSTACK: begin
          if (scl_rise && sda_f) begin
            state_reg <= DEV_IGNORE; // R17
          end else if (scl_rise) begin
            bit_cnt_reg <= 4'h9;
          end else if (scl_fall && bit_cnt_reg == 4'h9) begin
            sda_oe_reg  <= ~tx_reg[23];
            bit_cnt_reg <= 4'h0;
            state_reg   <= DEV_SEND;
          end
        end
        default: begin
          state_reg <= DEV_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  logic is_reset;
  logic is_conversion_select_bit;
  logic is_cal;
  logic is_adc;
  assign is_reset = (rx_reg == `CMD_RESET);
  assign is_adc   = (rx_reg == `CMD_ADC_READ);
  assign is_conversion_select_bit  = ((rx_reg[7:4] == `CMD_GRP_PRES) || (rx_reg[7:4] == `CMD_GRP_TEMP))
                    && !rx_reg[0] && (rx_reg[`CMD_SEL_MSB:`CMD_SEL_LSB] <= `OSR_SEL_MAX);
  assign is_cal   = (rx_reg[7:4] == `CMD_GRP_CAL) && !rx_reg[0]; // R6

  // ----------------------------------------------------------------
  // Calibration store
  // ----------------------------------------------------------------
  // Internal copy is empty until the reset command loads it
  localparam logic [15:0] CAL_ROM [0:`CAL_WORDS-1] = '{`CAL_WORD0, `CAL_WORD1, // R14
    `CAL_WORD2, `CAL_WORD3, `CAL_WORD4, `CAL_WORD5, `CAL_WORD6};
  logic [15:0] cal_mem [0:`CAL_WORDS-1]; // R13

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      for (int i = 0; i < `CAL_WORDS; i++) begin
        cal_mem[i] <= 16'h0000;
      end
      cal_loaded <= 1'b0;
    end else if (cmd_exec && is_reset) begin
      for (int i = 0; i < `CAL_WORDS; i++) begin
        cal_mem[i] <= CAL_ROM[i]; // R9 R10
      end
      cal_loaded <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Read mode and answer word
  // ----------------------------------------------------------------
  baro_mode_type mode_reg;
  logic [2:0]    cal_idx_reg;
  logic [23:0]   result_reg;
  logic          result_valid_reg;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mode_reg    <= MODE_NONE;
      cal_idx_reg <= 3'h0;
    end else if (cmd_exec) begin
      if (is_reset) begin
        mode_reg <= MODE_NONE; // R9
      end else if (is_adc) begin
        mode_reg <= MODE_ADC; // R4
      end else if (is_cal) begin
        mode_reg    <= MODE_CAL; // R16
        cal_idx_reg <= rx_reg[`CMD_SEL_MSB:`CMD_SEL_LSB]; // R6
      end
    end
  end

  always_comb begin
    rd_word = 24'h000000;
    unique case (mode_reg)
      MODE_ADC: begin
        rd_word = result_valid_reg ? result_reg : 24'h000000; // R4 R19
      end
      MODE_CAL: begin
        // Index 7 has no word behind it and reads zero
        if (cal_idx_reg < 3'(`CAL_WORDS)) begin
          rd_word = {cal_mem[cal_idx_reg], 8'hFF}; // R5 R15
        end else begin
          rd_word = 24'h0000FF;
        end
      end
      MODE_NONE: begin
        rd_word = 24'h000000;
      end
      default: begin
        rd_word = 24'h000000;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Conversion sequencer
  // ----------------------------------------------------------------
  // Sample is taken at the end of the interval, longer for higher ratios
  logic [15:0] conversion_select_bit_cnt_reg;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      conversion_select_bit_busy    <= 1'b0;
      conversion_select_bit_cnt_reg <= 16'h0000;
      meas_temp    <= 1'b0;
      osr_sel      <= 3'h0;
    end else if (cmd_exec && is_reset) begin
      conversion_select_bit_busy    <= 1'b0; // R10
      conversion_select_bit_cnt_reg <= 16'h0000;
    end else if (cmd_exec && is_conversion_select_bit) begin
      conversion_select_bit_busy    <= 1'b1; // R20
      conversion_select_bit_cnt_reg <= `CONVERSION_SELECT_BIT_UNIT_CYCLES << rx_reg[`CMD_SEL_MSB:`CMD_SEL_LSB];
      meas_temp    <= rx_reg[`CMD_TYPE_BIT]; // R7 R8
      osr_sel      <= rx_reg[`CMD_SEL_MSB:`CMD_SEL_LSB]; // R7 R8
    end else if (conversion_select_bit_busy) begin
      if (conversion_select_bit_cnt_reg == 16'h0001) begin
        conversion_select_bit_busy <= 1'b0; // R20
      end
      conversion_select_bit_cnt_reg <= conversion_select_bit_cnt_reg - 16'h0001;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      result_reg       <= 24'h000000;
      result_valid_reg <= 1'b0;
    end else if (conversion_select_bit_busy && conversion_select_bit_cnt_reg == 16'h0001) begin
      result_reg       <= meas_temp ? temperature_sample : pressure_sample; // R4
      result_valid_reg <= 1'b1;
    end else if (cmd_exec && (is_reset || is_conversion_select_bit)) begin
      result_valid_reg <= 1'b0; // R19 R20
    end else if (rd_load && mode_reg == MODE_ADC) begin
      result_valid_reg <= 1'b0; // R19
    end
  end
endmodule : baro_device

// [logic/baro_regs.svh]
// Constants of the barometric sensor command link: addresses, codes, timing
// How it works
// R1 - One command per start-to-stop framed message
// R2 - Target address 1110110 plus direction bit
// R3 - Command is one byte after write address
// R4 - Result read 0x00 returns 24-bit latest result
// R5 - Calibration read returns one 16-bit word
// R6 - Codes 0xA0-0xAE, word index in bits 3..1
// R7 - 0x40-0x4A start pressure conversion, ratio steps
// R8 - 0x50-0x5A start temperature conversion, ratio steps
// R9 - Reset 0x1E reloads calibration store, clears state
// R10 - Reset command accepted in any state
// R11 - Controller clocks stuck bus free, then resets
// R12 - Controller reads calibration once after reset
// R13 - Store holds seven 16-bit words
// R14 - Words hold setup, coefficients, serial, check
// R15 - Calibration word sent as two bytes MSB-first
// R16 - Calibration read: command message, then read message
// R17 - Read: controller acks bytes, nacks last, stops
// R18 - Write: device acks address and command byte
// R19 - Result read without fresh result returns zero
// R20 - Busy from conversion command until it finishes
`ifndef BARO_REGS_SVH
`define BARO_REGS_SVH

`define BARO_ADDR          7'h76
`define CMD_RESET          8'h1E
`define CMD_ADC_READ       8'h00
`define CMD_GRP_PRES       4'h4
`define CMD_GRP_TEMP       4'h5
`define CMD_GRP_CAL        4'hA
`define CMD_TYPE_BIT       4
`define CMD_SEL_MSB        3
`define CMD_SEL_LSB        1
`define OSR_SEL_MAX        3'h5
`define CAL_WORDS          7
`define CAL_LAST_CMD       8'hAC
`define CAL_WORD0          16'h0C0D
`define CAL_WORD1          16'h1111
`define CAL_WORD2          16'h2222
`define CAL_WORD3          16'h3333
`define CAL_WORD4          16'h4444
`define CAL_WORD5          16'h5555
`define CAL_WORD6          16'h6606
`define CONVERSION_SELECT_BIT_UNIT_CYCLES   16'h0040
`define SYS_CLK_NS         4
`define SCL_QTR_NS         80
`define SCL_QTR_CYCLES     ((`SCL_QTR_NS) / (`SYS_CLK_NS))

`endif

// [logic/baro_pkg.sv]
// Types shared by both ends of the sensor command link
package baro_pkg;
  typedef enum logic [2:0] {DEV_IDLE, DEV_ADDR, DEV_CMD, DEV_SEND, DEV_HOSTACK,
                            DEV_IGNORE} baro_dev_state_type;
  typedef enum logic [1:0] {MODE_NONE, MODE_ADC, MODE_CAL} baro_mode_type;
  typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} baro_host_state_type;
  typedef enum logic [1:0] {REQ_WRITE, REQ_READ, REQ_RECOVER} baro_req_type;
endpackage : baro_pkg

// [logic/baro_bus_if.sv]
// Two-wire open-drain bus joining controller and sensor
`timescale 1ns/100ps
interface baro_bus_if;
  logic host_scl_out;
  logic host_scl_oe;
  logic host_sda_out;
  logic host_sda_oe;
  logic dev_sda_out;
  logic dev_sda_oe;
  logic scl;
  logic sda;

  // Wired-AND with pull-ups: any enabled driver pulls the line low
  assign scl = ~(host_scl_oe & ~host_scl_out);
  assign sda = ~((host_sda_oe & ~host_sda_out) | (dev_sda_oe & ~dev_sda_out));

  modport dev  (input scl, input sda, output dev_sda_out, output dev_sda_oe);
  modport host (input scl, input sda, output host_scl_out, output host_scl_oe,
                output host_sda_out, output host_sda_oe);
endinterface : baro_bus_if

// [logic/baro_pin_sync.sv]
// Three-stage pin synchroniser; level moves once stages two and three agree
`timescale 1ns/100ps
module baro_pin_sync (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic pin,
  output logic      level
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s1_reg <= 1'b1;
      s2_reg <= 1'b1;
      s3_reg <= 1'b1;
    end else begin
      s1_reg <= pin;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      level <= 1'b1;
    end else if (s2_reg == s3_reg) begin
      level <= s3_reg;
    end
  end
endmodule : baro_pin_sync

// [logic/baro_host.sv]
// Controller end: drives clock and frames, sends commands, fetches answers
`timescale 1ns/100ps
`include "baro_regs.svh"
module baro_host import baro_pkg::*; (
  input  wire logic   sys_clk,
  input  wire logic   rst,
  baro_bus_if.host    bus,
  input  wire logic   req_valid,
  input  wire logic [1:0] req_kind,
  input  wire logic [7:0] req_cmd,
  input  wire logic [1:0] req_len,
  output logic        busy,
  output logic        done,
  output logic        ack_error,
  output logic [23:0] rd_data,
  output logic        cal_fetch_pending
);
  // ----------------------------------------------------------------
  // Pins
  // ----------------------------------------------------------------
  logic sda_s;
  logic scl_oe_reg;
  logic sda_oe_reg;

  baro_pin_sync u_sda_sync (
    .sys_clk (sys_clk),
    .rst     (rst),
    .pin     (bus.sda),
    .level   (sda_s)
  );

  assign bus.host_scl_out = 1'b0;
  assign bus.host_sda_out = 1'b0;
  assign bus.host_scl_oe  = scl_oe_reg;
  assign bus.host_sda_oe  = sda_oe_reg;

  // ----------------------------------------------------------------
  // Quarter-bit timing
  // ----------------------------------------------------------------
  localparam logic [9:0] QTR = 10'(`SCL_QTR_CYCLES);
  logic [9:0] qtr_cnt_reg;
  logic       tick;
  assign tick = (qtr_cnt_reg == 10'h000);

  always_ff @(posedge sys_clk) begin
    if (rst || tick) begin
      qtr_cnt_reg <= QTR - 10'h001;
    end else begin
      qtr_cnt_reg <= qtr_cnt_reg - 10'h001;
    end
  end

  // ----------------------------------------------------------------
  // Frame sequencer
  // ----------------------------------------------------------------
  baro_host_state_type state_reg;
  baro_req_type kind_reg;
  logic [1:0] phase_reg;
  logic [3:0] bit_reg;
  logic [1:0] frame_reg;
  logic [1:0] last_frame_reg;
  logic [7:0] cmd_reg;
  logic [7:0] frame_byte;
  logic       drive_low;
  logic       data_frame;

  assign data_frame = (kind_reg == REQ_READ) && (frame_reg != 2'h0);

  always_comb begin
    frame_byte = (frame_reg == 2'h0) ? {`BARO_ADDR, kind_reg == REQ_READ} : cmd_reg; // R2 R3
    drive_low  = 1'b0;
    if (kind_reg == REQ_RECOVER) begin
      drive_low = 1'b0; // R11
    end else if (bit_reg == 4'h8) begin
      drive_low = data_frame && (frame_reg != last_frame_reg); // R17
    end else if (!data_frame) begin
      drive_low = ~frame_byte[3'(4'h7 - bit_reg)];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_reg      <= H_IDLE;
      kind_reg       <= REQ_WRITE;
      phase_reg      <= 2'h0;
      bit_reg        <= 4'h0;
      frame_reg      <= 2'h0;
      last_frame_reg <= 2'h0;
      cmd_reg        <= 8'h00;
      scl_oe_reg     <= 1'b0;
      sda_oe_reg     <= 1'b0;
      busy           <= 1'b0;
      done           <= 1'b0;
      ack_error      <= 1'b0;
      rd_data        <= 24'h000000;
    end else begin
      done <= 1'b0;
      if (state_reg == H_IDLE) begin
        if (req_valid) begin
          busy      <= 1'b1;
          ack_error <= 1'b0;
          kind_reg  <= baro_req_type'(req_kind);
          cmd_reg   <= req_cmd;
          rd_data   <= 24'h000000;
          unique case (req_kind)
            2'h1:    last_frame_reg <= req_len;
            2'h2:    last_frame_reg <= 2'h0;
            default: last_frame_reg <= 2'h1;
          endcase
          frame_reg <= 2'h0;
          bit_reg   <= 4'h0;
          phase_reg <= 2'h0;
          state_reg <= (req_kind == 2'h2) ? H_BIT : H_START;
        end
      end else if (tick) begin
        phase_reg <= phase_reg + 2'h1;
        unique case (state_reg)
          H_START: begin
            if (phase_reg == 2'h1) begin
              sda_oe_reg <= 1'b1; // R1
            end else if (phase_reg == 2'h2) begin
              scl_oe_reg <= 1'b1;
              phase_reg  <= 2'h0;
              state_reg  <= H_BIT;
            end
          end
          H_BIT: begin
            unique case (phase_reg)
              2'h0: begin
                scl_oe_reg <= 1'b1;
                sda_oe_reg <= drive_low;
              end
              2'h1: scl_oe_reg <= 1'b0;
              2'h2: begin
                if (bit_reg == 4'h8 && !data_frame && sda_s && kind_reg != REQ_RECOVER) begin
                  ack_error <= 1'b1; // R18
                end
                if (bit_reg < 4'h8 && data_frame) begin
                  rd_data <= {rd_data[22:0], sda_s};
                end
              end
              2'h3: begin
                scl_oe_reg <= 1'b1;
                bit_reg    <= bit_reg + 4'h1;
                if (bit_reg == 4'h8) begin
                  bit_reg   <= 4'h0;
                  frame_reg <= frame_reg + 2'h1;
                  if (frame_reg == last_frame_reg || ack_error) begin
                    state_reg <= H_STOP; // R17
                  end
                end
              end
              default: ;
            endcase
          end
          H_STOP: begin
            unique case (phase_reg)
              2'h0: sda_oe_reg <= 1'b1;
              2'h1: scl_oe_reg <= 1'b0;
              2'h2: sda_oe_reg <= 1'b0; // R1
              2'h3: begin
                state_reg <= H_IDLE;
                busy      <= 1'b0;
                done      <= 1'b1;
              end
              default: ;
            endcase
          end
          default: state_reg <= H_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Calibration bookkeeping
  // ----------------------------------------------------------------
  // Raised by a sent reset; cleared once the last word has been fetched
  logic [7:0] last_cmd_reg;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cal_fetch_pending <= 1'b0;
      last_cmd_reg      <= 8'h00;
    end else if (done && !ack_error && kind_reg == REQ_WRITE) begin
      last_cmd_reg <= cmd_reg;
      if (cmd_reg == `CMD_RESET) begin
        cal_fetch_pending <= 1'b1; // R9 R12
      end
    end else if (done && kind_reg == REQ_READ && last_cmd_reg == `CAL_LAST_CMD) begin
      cal_fetch_pending <= 1'b0; // R12 R16
    end
  end
endmodule : baro_host

// [tb/baro_link_chk.sv]
// Protocol checker watching the two-wire bus between controller and sensor
`timescale 1ns/100ps
`include "baro_regs.svh"
module baro_link_chk (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic host_scl_out,
  input wire logic host_scl_oe,
  input wire logic host_sda_out,
  input wire logic host_sda_oe,
  input wire logic dev_sda_out,
  input wire logic dev_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  logic        scl_q_reg, sda_q_reg, in_frame_reg, rw_reg;
  logic [5:0]  bit_cnt_reg;
  logic [7:0]  shift_reg;
  logic [11:0] hi_cnt_reg, lo_cnt_reg;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  // ----
  // Helper state
  // ----
  // High count starts saturated so the first clock after reset is not flagged
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      scl_q_reg  <= 1'b1;
      sda_q_reg  <= 1'b1;
      hi_cnt_reg <= 12'hFFF;
      lo_cnt_reg <= 12'h000;
    end else begin
      scl_q_reg  <= scl;
      sda_q_reg  <= sda;
      hi_cnt_reg <= scl ? hi_cnt_reg + {11'h000, ~&hi_cnt_reg} : 12'h000;
      lo_cnt_reg <= scl ? 12'h000 : lo_cnt_reg + {11'h000, ~&lo_cnt_reg};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      in_frame_reg <= 1'b0;
      bit_cnt_reg  <= 6'h00;
      shift_reg    <= 8'h00;
      rw_reg       <= 1'b0;
    end else if (scl && sda_q_reg && !sda) begin
      in_frame_reg <= 1'b1;
      bit_cnt_reg  <= 6'h00;
    end else if (scl && !sda_q_reg && sda) begin
      in_frame_reg <= 1'b0;
    end else if (scl && !scl_q_reg && in_frame_reg) begin
      bit_cnt_reg <= bit_cnt_reg + 6'h01;
      shift_reg   <= {shift_reg[6:0], sda};
      if (bit_cnt_reg == 6'h07) begin
        rw_reg <= sda;
      end
    end
  end

  // ----
  // Assertions
  // ----
  sequence start_s; scl && $fell(sda); endsequence
  sequence stop_s; scl && $rose(sda); endsequence

  start_hold_a: assert property (start_s |=> (!sda)[*8] ##[0:700] !scl)
    else $error("start condition malformed");
  // The clock rise inside the stop is counted and shifted as one more bit
  frame_bits_a: assert property (stop_s ##0 in_frame_reg |->
    (rw_reg ? (bit_cnt_reg == 6'h1C || bit_cnt_reg == 6'h25) : bit_cnt_reg == 6'h13))
    else $error("wrong bit count in message");
  host_nack_a: assert property (stop_s ##0 (in_frame_reg && rw_reg) |-> shift_reg[1])
    else $error("last read byte not refused");
  addr_match_a: assert property ($rose(scl) && in_frame_reg && bit_cnt_reg == 6'h07
    |-> shift_reg[6:0] == 7'h76) else $error("wrong target address");
  addr_ack_a: assert property ($rose(scl) && in_frame_reg && bit_cnt_reg == 6'h08 |-> !sda)
    else $error("address not acknowledged");
  cmd_ack_a: assert property ($rose(scl) && in_frame_reg && !rw_reg
    && bit_cnt_reg == 6'h11 |-> !sda) else $error("command byte not acknowledged");
  dev_edge_a: assert property (!$stable(dev_sda_oe) |-> !scl)
    else $error("sensor changed data while clock high");
  dev_frame_a: assert property (dev_sda_oe |-> in_frame_reg)
    else $error("sensor drives outside a message");
  scl_high_a: assert property ($fell(scl) |-> hi_cnt_reg >= 12'(`SCL_QTR_CYCLES))
    else $error("clock high phase too short");
  scl_low_a: assert property ($rose(scl) |-> lo_cnt_reg >= 12'(`SCL_QTR_CYCLES))
    else $error("clock low phase too short");
  od_values_a: assert property (!(host_scl_out || host_sda_out || dev_sda_out)
    && (!host_sda_oe || !sda) && (!host_scl_oe || !scl)) else $error("open-drain misuse");
endmodule : baro_link_chk

// [tb/test_baro_sensor_i2c_commands.sv]
// Bench joining controller and sensor ends, checked against a command model
`timescale 1ns/100ps
`include "baro_regs.svh"
module test_baro_sensor_i2c_commands;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic        req_valid, busy, done, ack_error, cal_fetch_pending;
  logic        conversion_select_bit_busy, cal_loaded, meas_temp;
  logic [1:0]  req_kind, req_len;
  logic [7:0]  req_cmd;
  logic [2:0]  osr_sel;
  logic [23:0] rd_data, pressure_sample, temperature_sample;
  int          n_mismatch, checked, busy_cnt, exp_conversion_select_bit, mdl_mode, mdl_idx, mdl_res, seed, idx;
  bit          cal_ok;
  int          cal_tab [7] = '{`CAL_WORD0, `CAL_WORD1, `CAL_WORD2, `CAL_WORD3,
                               `CAL_WORD4, `CAL_WORD5, `CAL_WORD6};

  always #2 sys_clk = ~sys_clk;

  // ----
  // Both ends and the checker
  // ----
  baro_bus_if baro_bus_if_inst ();
  baro_device baro_device_inst (.sys_clk(sys_clk), .rst(rst), .bus(baro_bus_if_inst),
    .pressure_sample(pressure_sample), .temperature_sample(temperature_sample),
    .conversion_select_bit_busy(conversion_select_bit_busy), .cal_loaded(cal_loaded), .meas_temp(meas_temp), .osr_sel(osr_sel));
  baro_host baro_host_inst (.sys_clk(sys_clk), .rst(rst), .bus(baro_bus_if_inst),
    .req_valid(req_valid), .req_kind(req_kind), .req_cmd(req_cmd), .req_len(req_len),
    .busy(busy), .done(done), .ack_error(ack_error), .rd_data(rd_data),
    .cal_fetch_pending(cal_fetch_pending));
  baro_link_chk baro_link_chk_inst (.sys_clk(sys_clk), .rst(rst),
    .host_scl_out(baro_bus_if_inst.host_scl_out), .host_scl_oe(baro_bus_if_inst.host_scl_oe),
    .host_sda_out(baro_bus_if_inst.host_sda_out), .host_sda_oe(baro_bus_if_inst.host_sda_oe),
    .dev_sda_out(baro_bus_if_inst.dev_sda_out), .dev_sda_oe(baro_bus_if_inst.dev_sda_oe),
    .scl(baro_bus_if_inst.scl), .sda(baro_bus_if_inst.sda));

  // ----
  // Tasks
  // ----
  task check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task summarize();
    if (n_mismatch == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : summarize

  task req(input logic [1:0] kind, input logic [7:0] cmd, input logic [1:0] len);
    int n;
    @(posedge sys_clk);
    #1 {req_valid, req_kind, req_cmd, req_len} = {1'b1, kind, cmd, len};
    @(posedge sys_clk);
    #1 req_valid = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 20000) begin
      @(posedge sys_clk);
      #1 n++;
    end
    if (n >= 20000) begin
      n_mismatch++;
      summarize();
    end
    if (kind != 2'h2) check("ack_error", {23'h0, ack_error}, 24'h0);
  endtask : req

  // Model follows each command written; conversions are waited out before reads
  task wr(input logic [7:0] cmd);
    req(2'h0, cmd, 2'h1);
    if (cmd == 8'h1E) {cal_ok, mdl_res, mdl_mode} = {1'b1, 32'sd0, 32'sd0};
    else if (cmd == 8'h00) mdl_mode = 1;
    else if (cmd[7:4] == 4'hA) {mdl_mode, mdl_idx} = {32'sd2, 29'h0, cmd[3:1]};
    else mdl_res = cmd[4] ? temperature_sample : pressure_sample;
  endtask : wr

  task rd(input logic [1:0] len);
    int e;
    req(2'h1, 8'h00, len);
    if (mdl_mode == 1) {e, mdl_res} = {mdl_res, 32'sd0};
    else e = (cal_ok && mdl_idx < 7) ? cal_tab[mdl_idx] : 0;
    check("rd_data", len == 2'h2 ? {8'h00, rd_data[15:0]} : rd_data, e[23:0]);
  endtask : rd

  always @(negedge sys_clk) begin
    if (conversion_select_bit_busy === 1'b1) busy_cnt++;
    else if (busy_cnt != 0) begin
      check("conversion_select_bit_time", {23'h0, busy_cnt >= exp_conversion_select_bit && busy_cnt <= exp_conversion_select_bit + 3}, 24'h1);
      busy_cnt = 0;
    end
  end

  // ----
  // Sequence
  // ----
  initial begin
    {req_valid, req_kind, req_len, req_cmd} = 13'h0000;
    {pressure_sample, temperature_sample} = 48'h0;
    seed = $urandom(14);
    repeat (2) @(posedge sys_clk);
    #1 rst = 1'b0;
    check("cal_loaded", {23'h0, cal_loaded}, 24'h0);
    req(2'h2, 8'h00, 2'h0);
    wr(8'h1E);
    @(posedge sys_clk);
    #1 check("cal_loaded", {23'h0, cal_loaded}, 24'h1);
    check("cal_fetch_pending", {23'h0, cal_fetch_pending}, 24'h1);
    idx = $urandom_range(5, 0);
    wr({4'hA, idx[2:0], 1'b0});
    rd(2'h2);
    wr(8'hAC);
    rd(2'h2);
    @(posedge sys_clk);
    #1 check("cal_fetch_pending", {23'h0, cal_fetch_pending}, 24'h0);
    wr(8'hAE);
    rd(2'h2);
    wr(8'h00);
    rd(2'h3);
    for (int k = 0; k < 12; k++) begin
      pressure_sample = 24'($urandom);
      temperature_sample = 24'($urandom);
      exp_conversion_select_bit = 64 << (k % 6);
      wr(8'(64 + (k / 6) * 16 + (k % 6) * 2));
      check("osr_sel", {21'h0, osr_sel}, 24'(k % 6));
      check("meas_temp", {23'h0, meas_temp}, 24'(k / 6));
      for (int n = 0; n < 4096 && conversion_select_bit_busy !== 1'b0; n++) @(posedge sys_clk);
      #1 check("conversion_select_bit_busy", {23'h0, conversion_select_bit_busy}, 24'h0);
    end
    wr(8'h00);
    rd(2'h3);
    wr(8'h00);
    rd(2'h3);
    summarize();
  end

  initial begin
    #400000;
    n_mismatch++;
    summarize();
  end
endmodule : test_baro_sensor_i2c_commands
